// ### rtl/lchc_cmd_port.sv
// Summary of operation
// [R1] Calibration write: 16 bytes, scale, gain floats, then tare and reference.
// [R2] Top byte of the reference offset is dropped; 24 bits kept.
// [R3] Received calibration values go to nonvolatile store, used for weight.
// [R4] Mode query answers one of five modes.
// [R5] A recognised mode code switches operation to that mode.
// [R6] An unrecognised mode code selects calibration mode.
// [R7] Weight = scale*gain*(raw-ref-tare); weight query returns latest as float.
// [R8] Host writes next byte only after input-full flag clears.
// [R9] Each response byte is loaded to output register and flagged available.
// [R10] Host rereads calibration after an interrupted calibration write.
// [R11] Calibration read returns 15 bytes; reference as three bytes.
// [R12] Raw query returns latest 24-bit conversion as three bytes.
// [R13] Opcodes and mode codes are shared constants; values sent LSB first.
// [R14] Commands accepted only when idle; idle again after last data byte.
`timescale 1ns/1ps
`default_nettype none
module lchc_cmd_port (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic in_wr_i,
  input wire logic [7:0] in_data_i,
  input wire logic out_rd_i,
  input wire logic raw_valid_i,
  input wire logic [lchc_pkg::RAW_W-1:0] raw_i,
  input wire logic [31:0] weight_i,
  output logic in_full_o,
  output logic out_full_o,
  output logic [7:0] out_data_o,
  output logic [2:0] mode_o,
  output logic [31:0] scale_o,
  output logic [31:0] gain_o,
  output logic [31:0] offset_o
);
  import lchc_pkg::*;
  lchc_state_e state_q, state_d;
  logic in_full_q, out_full_q;
  logic [7:0] in_byte_q, out_data_q;
  logic [7:0] cmd_q;
  logic [4:0] idx_q, len_q;
  logic [31:0] asm_q;
  logic [2:0] mode_q;
  logic [RAW_W-1:0] raw_q;
  logic [31:0] weight_q;
  logic [31:0] scale_q, gain_q, offset_q;
  logic nv_we;
  logic [1:0] nv_addr;
  logic [31:0] nv_wdata, nv_scale, nv_gain, nv_tare, nv_ref;

  lchc_nvmem #(.WORDS(4)) u_nv (
    .clk_i(clk_i),
    .we_i(nv_we),
    .waddr_i(nv_addr),
    .wdata_i(nv_wdata),
    .scale_o(nv_scale),
    .gain_o(nv_gain),
    .tare_o(nv_tare),
    .ref_o(nv_ref)
  );

  function automatic logic [2:0] mode_of(input logic [7:0] code);
    unique case (code)
      MODE_CHECK: mode_of = 3'h0;
      MODE_MOTION: mode_of = 3'h1;
      MODE_CONT: mode_of = 3'h2;
      MODE_FILL: mode_of = 3'h3;
      default: mode_of = 3'h4; // [R6]
    endcase
  endfunction

  function automatic logic [4:0] len_of(input logic [7:0] cmd);
    unique case (cmd)
      CMD_SET_CAL: len_of = SET_CAL_BYTES;
      CMD_GET_CAL: len_of = GET_CAL_BYTES;
      CMD_SET_MODE, CMD_GET_MODE: len_of = MODE_BYTES;
      CMD_GET_WEIGHT: len_of = WEIGHT_BYTES;
      CMD_GET_RAW: len_of = RAW_BYTES;
      default: len_of = 5'h00;
    endcase
  endfunction

  wire byte_ready = in_full_q && !in_wr_i;
  wire is_rx_cmd = (in_byte_q == CMD_SET_CAL) || (in_byte_q == CMD_SET_MODE);
  wire [4:0] cmd_len = len_of(in_byte_q);
  wire last_of_word = (idx_q[1:0] == 2'h3);
  wire [31:0] asm_next = {in_byte_q, asm_q[31:8]}; // [R13]
  // Low three bytes already sit in the bottom of the assembled word
  wire [RAW_W-1:0] ref_low = asm_next[RAW_W-1:0]; // [R2]
  wire [7:0] mode_code = {5'h00, mode_q}; // [R4]

  // Transmit byte selection, LSB first
  wire [4:0] tx_idx = idx_q;
  wire [1:0] tx_lane = tx_idx[1:0];
  wire [31:0] cal_word = (tx_idx < IDX_GAIN) ? nv_scale :
                         (tx_idx < IDX_TARE) ? nv_gain :
                         (tx_idx < IDX_REF) ? nv_tare : nv_ref;
  wire [31:0] tx_word = (cmd_q == CMD_GET_CAL) ? cal_word : // [R11]
                        (cmd_q == CMD_GET_MODE) ? {24'h000000, mode_code} :
                        (cmd_q == CMD_GET_WEIGHT) ? weight_q : // [R7]
                        {8'h00, raw_q}; // [R12]
  wire [7:0] tx_byte = tx_word[tx_lane*BYTE_W +: BYTE_W];

  assign nv_we = (state_q == ST_RX) && byte_ready && cmd_q == CMD_SET_CAL
                 && last_of_word; // [R3]
  assign nv_addr = idx_q[3:2];
  assign nv_wdata = (idx_q == IDX_REF_TOP) ? {8'h00, ref_low} : asm_next; // [R2]

  always_comb begin
    state_d = state_q;
    unique case (state_q)
      ST_IDLE: if (byte_ready && cmd_len != 5'h00) begin // [R14]
        state_d = is_rx_cmd ? ST_RX : ST_TX;
      end
      ST_RX: if (byte_ready && idx_q == len_q - 5'h01) begin
        state_d = ST_IDLE; // [R14]
      end
      ST_TX: if (!out_full_q && idx_q == len_q) begin
        state_d = ST_IDLE; // [R14]
      end
      ST_MODE: state_d = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      state_q <= ST_IDLE;
      in_full_q <= 1'b0;
      in_byte_q <= 8'h00;
    end else begin
      state_q <= state_d;
      if (in_wr_i) begin
        in_full_q <= 1'b1; // [R8]
        in_byte_q <= in_data_i;
      end else if (byte_ready) begin
        in_full_q <= 1'b0; // [R8]
      end
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      cmd_q <= 8'h00;
      idx_q <= 5'h00;
      len_q <= 5'h00;
      asm_q <= 32'h00000000;
      mode_q <= 3'h4;
    end else begin
      if (state_q == ST_IDLE && byte_ready) begin
        cmd_q <= in_byte_q;
        len_q <= cmd_len;
        idx_q <= 5'h00;
      end else if (state_q == ST_RX && byte_ready) begin
        asm_q <= asm_next; // [R1]
        idx_q <= idx_q + 5'h01;
        if (cmd_q == CMD_SET_MODE) begin
          mode_q <= mode_of(in_byte_q); // [R5] [R6]
        end
      end else if (state_q == ST_TX && !out_full_q && idx_q != len_q) begin
        idx_q <= idx_q + 5'h01;
      end
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      out_full_q <= 1'b0;
      out_data_q <= 8'h00;
    end else if (state_q == ST_TX && !out_full_q && idx_q != len_q) begin
      out_full_q <= 1'b1; // [R9]
      out_data_q <= tx_byte;
    end else if (out_rd_i) begin
      out_full_q <= 1'b0;
    end
  end

  // Latest conversion and the weight snapshot taken with it
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      raw_q <= '0;
      weight_q <= 32'h00000000;
      scale_q <= 32'h00000000;
      gain_q <= 32'h00000000;
      offset_q <= 32'h00000000;
    end else begin
      if (raw_valid_i) begin
        raw_q <= raw_i;
        weight_q <= weight_i; // [R7]
      end
      scale_q <= nv_scale;
      gain_q <= nv_gain;
      offset_q <= nv_ref + nv_tare; // [R7]
    end
  end

  assign in_full_o = in_full_q;
  assign out_full_o = out_full_q;
  assign out_data_o = out_data_q;
  assign mode_o = mode_q;
  assign scale_o = scale_q;
  assign gain_o = gain_q;
  assign offset_o = offset_q;
endmodule
`default_nettype wire

// ### rtl/lchc_pkg.sv
package lchc_pkg;
  localparam int BYTE_W = 8;
  localparam int RAW_W = 24;
  localparam int WORD_W = 32;
  // Command opcodes, shared with host software
  localparam logic [7:0] CMD_SET_CAL = 8'h01;
  localparam logic [7:0] CMD_GET_CAL = 8'h02;
  localparam logic [7:0] CMD_SET_MODE = 8'h03;
  localparam logic [7:0] CMD_GET_MODE = 8'h04;
  localparam logic [7:0] CMD_GET_WEIGHT = 8'h05;
  localparam logic [7:0] CMD_GET_RAW = 8'h06;
  // Mode codes
  localparam logic [7:0] MODE_CHECK = 8'h00;
  localparam logic [7:0] MODE_MOTION = 8'h01;
  localparam logic [7:0] MODE_CONT = 8'h02;
  localparam logic [7:0] MODE_FILL = 8'h03;
  localparam logic [7:0] MODE_CAL = 8'h04;
  // Byte counts
  localparam logic [4:0] SET_CAL_BYTES = 5'h10;
  localparam logic [4:0] GET_CAL_BYTES = 5'h0F;
  localparam logic [4:0] MODE_BYTES = 5'h01;
  localparam logic [4:0] WEIGHT_BYTES = 5'h04;
  localparam logic [4:0] RAW_BYTES = 5'h03;
  // Byte index where each calibration value starts, the reference top byte, and store word addresses
  localparam logic [4:0] IDX_GAIN = 5'h04;
  localparam logic [4:0] IDX_TARE = 5'h08;
  localparam logic [4:0] IDX_REF = 5'h0C;
  localparam logic [4:0] IDX_REF_TOP = 5'h0F;
  localparam logic [1:0] NV_SCALE = 2'h0;
  localparam logic [1:0] NV_GAIN = 2'h1;
  localparam logic [1:0] NV_TARE = 2'h2;
  localparam logic [1:0] NV_REF = 2'h3;
  localparam logic [31:0] FLOAT_ONE = 32'h3F800000;
  typedef enum logic [2:0] {
    ST_IDLE, ST_RX, ST_TX, ST_MODE
  } lchc_state_e;
endpackage

// ### rtl/lchc_nvmem.sv
`timescale 1ns/1ps
`default_nettype none
// Nonvolatile calibration store; contents survive reset, only writes change them
module lchc_nvmem #(
  parameter int WORDS = 4
) (
  input wire logic clk_i,
  input wire logic we_i,
  input wire logic [1:0] waddr_i,
  input wire logic [31:0] wdata_i,
  output logic [31:0] scale_o,
  output logic [31:0] gain_o,
  output logic [31:0] tare_o,
  output logic [31:0] ref_o
);
  import lchc_pkg::*;
  logic [31:0] mem_q [WORDS];
  initial begin
    mem_q[NV_SCALE] = FLOAT_ONE;
    mem_q[NV_GAIN] = FLOAT_ONE;
    mem_q[NV_TARE] = 32'h00000000;
    mem_q[NV_REF] = 32'h00000000;
  end
  always_ff @(posedge clk_i) begin
    if (we_i) begin
      mem_q[waddr_i] <= wdata_i;
    end
  end
  assign scale_o = mem_q[NV_SCALE];
  assign gain_o = mem_q[NV_GAIN];
  assign tare_o = mem_q[NV_TARE];
  assign ref_o = mem_q[NV_REF];
endmodule
`default_nettype wire

// ### testbench/lchc_cmd_port_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module lchc_cmd_port_asserts (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic in_wr_i,
  input wire logic out_rd_i,
  input wire logic in_full_o,
  input wire logic out_full_o,
  input wire logic [7:0] out_data_o,
  input wire logic [2:0] mode_o,
  input wire logic [31:0] gain_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  a_full_after_wr: assert property (in_wr_i && !in_full_o |=> in_full_o)
    else $error("input flag not raised");
  a_full_one_cycle: assert property (in_full_o |=> !in_full_o)
    else $error("input byte not consumed");
  a_out_holds: assert property (out_full_o && !out_rd_i |=> out_full_o)
    else $error("output flag dropped unread");
  a_out_data_stable: assert property (out_full_o && !out_rd_i |=> $stable(out_data_o))
    else $error("output byte changed unread");
  a_out_clear: assert property (out_rd_i && out_full_o |=> !out_full_o)
    else $error("output flag not cleared");
  a_mode_legal: assert property (mode_o <= 3'h4)
    else $error("mode out of range");
  a_cal_quiet: assert property ($changed(gain_o) && !$past(rst_i) && !$past(rst_i, 2) |->
    $past(in_wr_i) || $past(in_wr_i, 2) || $past(in_wr_i, 3) || $past(in_wr_i, 4))
    else $error("calibration changed without a write");
  a_reset_idle: assert property ($fell(rst_i) |->
    mode_o == 3'h4 && !in_full_o && !out_full_o)
    else $error("not idle after reset");
  c_write: cover property (in_wr_i && !in_full_o);
  c_read: cover property (out_rd_i && out_full_o);
  c_mode: cover property ($changed(mode_o));
endmodule
bind lchc_cmd_port lchc_cmd_port_asserts u_chk (.clk_i(clk_i), .rst_i(rst_i),
  .in_wr_i(in_wr_i), .out_rd_i(out_rd_i), .in_full_o(in_full_o), .out_full_o(out_full_o),
  .out_data_o(out_data_o), .mode_o(mode_o), .gain_o(gain_o));
`default_nettype wire

// ### testbench/lchc_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module lchc_host_model (
  input wire logic clk_i,
  input wire logic in_full_i,
  input wire logic out_full_i,
  input wire logic [7:0] out_data_i,
  output logic in_wr_o,
  output logic [7:0] in_data_o,
  output logic out_rd_o
);
  initial begin
    in_wr_o = 1'b0;
    in_data_o = 8'h00;
    out_rd_o = 1'b0;
  end
  // Next byte only once the input flag has cleared
  task wr_byte(input logic [7:0] b);
    in_wr_o = 1'b1;
    in_data_o = b;
    @(posedge clk_i); #1;
    in_wr_o = 1'b0;
    in_data_o = ~b;
    @(posedge clk_i); #1;
    while (in_full_i) begin
      @(posedge clk_i); #1;
    end
  endtask
  // Byte taken only while flagged
  task rd_byte(output logic [7:0] b);
    while (!out_full_i) begin
      @(posedge clk_i); #1;
    end
    b = out_data_i;
    out_rd_o = 1'b1;
    @(posedge clk_i); #1;
    out_rd_o = 1'b0;
    @(posedge clk_i); #1;
  endtask
  // Least significant byte first
  task wr_n(input logic [31:0] v, input int n);
    for (int i = 0; i < n; i++) wr_byte(v[8*i+:8]);
  endtask
  task rd_n(output logic [31:0] v, input int n);
    logic [7:0] b;
    v = 32'h0;
    for (int i = 0; i < n; i++) begin
      rd_byte(b);
      v[8*i+:8] = b;
    end
  endtask
endmodule
`default_nettype wire

// ### testbench/load_cell_host_command_port_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module load_cell_host_command_port_tb_top;
  import lchc_pkg::*;
  localparam logic [31:0] SCL = 32'h3FC00000;
  localparam logic [31:0] GN = 32'h40000000;
  localparam logic [31:0] TR = 32'h00000100;
  localparam logic [31:0] RF = 32'hAB123456;
  logic clk_i = 1'b0, rst_i = 1'b1, raw_valid_i = 1'b0;
  logic [23:0] raw_i = 24'h0;
  logic [31:0] weight_i = 32'h0, scale_o, gain_o, offset_o, v;
  logic in_wr_i, out_rd_i, in_full_o, out_full_o;
  logic [7:0] in_data_i, out_data_o;
  logic [2:0] mode_o;
  int n_errors = 0, samples_checked = 0, cyc = 0;
  initial forever #50 clk_i = ~clk_i;
  lchc_cmd_port dut (.clk_i(clk_i), .rst_i(rst_i), .in_wr_i(in_wr_i), .in_data_i(in_data_i),
    .out_rd_i(out_rd_i), .raw_valid_i(raw_valid_i), .raw_i(raw_i), .weight_i(weight_i),
    .in_full_o(in_full_o), .out_full_o(out_full_o), .out_data_o(out_data_o), .mode_o(mode_o),
    .scale_o(scale_o), .gain_o(gain_o), .offset_o(offset_o));
  lchc_host_model h (.clk_i(clk_i), .in_full_i(in_full_o), .out_full_i(out_full_o),
    .out_data_i(out_data_o), .in_wr_o(in_wr_i), .in_data_o(in_data_i), .out_rd_o(out_rd_i));
  task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task final_report;
    $display("errors %0d, comparisons %0d", n_errors, samples_checked);
    if (n_errors == 0 && samples_checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task t_cal;
    h.wr_byte(CMD_SET_CAL);
    h.wr_n(SCL, 4); h.wr_n(GN, 4); h.wr_n(TR, 4); h.wr_n(RF, 4);
    repeat (3) @(posedge clk_i); #1;
    chk("scale", SCL, scale_o);
    chk("gain", GN, gain_o);
    chk("offset", TR + {8'h00, RF[23:0]}, offset_o);
    h.wr_byte(CMD_GET_CAL);
    h.rd_n(v, 4); chk("rd scale", SCL, v);
    h.rd_n(v, 4); chk("rd gain", GN, v);
    h.rd_n(v, 4); chk("rd tare", TR, v);
    h.rd_n(v, 3); chk("rd ref", {8'h00, RF[23:0]}, v);
    repeat (4) @(posedge clk_i); #1;
    chk("no 16th byte", 32'h0, {31'h0, out_full_o});
  endtask
  task t_modes;
    logic [7:0] codes [6] = '{MODE_CHECK, MODE_MOTION, MODE_CONT, MODE_FILL, MODE_CAL, 8'h07};
    logic [31:0] m;
    h.wr_byte(8'h77);
    h.wr_byte(CMD_GET_MODE); h.rd_n(v, 1); chk("mode after junk", 32'h4, v);
    foreach (codes[i]) begin
      h.wr_byte(CMD_SET_MODE); h.wr_byte(codes[i]);
      repeat (2) @(posedge clk_i); #1;
      m = (codes[i] > 8'h04) ? 32'h4 : {24'h0, codes[i]};
      chk("mode_o", m, {29'h0, mode_o});
      h.wr_byte(CMD_GET_MODE); h.rd_n(v, 1);
      chk("mode query", m, v);
    end
  endtask
  task t_data;
    raw_valid_i = 1'b1; raw_i = 24'h8ABCDE; weight_i = 32'h42F60000;
    @(posedge clk_i); #1;
    raw_valid_i = 1'b0; raw_i = 24'h754321; weight_i = 32'hBDBDBDBD;
    h.wr_byte(CMD_GET_RAW); h.rd_n(v, 3); chk("raw", 32'h008ABCDE, v);
    h.wr_byte(CMD_GET_WEIGHT); h.rd_n(v, 4); chk("weight", 32'h42F60000, v);
  endtask
  // Calibration must survive a reset in mid-run
  task t_rst;
    rst_i = 1'b1;
    @(posedge clk_i); #1;
    rst_i = 1'b0;
    @(posedge clk_i); #1;
    chk("scale kept", SCL, scale_o);
    chk("mode reset", 32'h4, {29'h0, mode_o});
    // Write cut short after one full word: only that word may have landed
    h.wr_byte(CMD_SET_CAL); h.wr_n(GN, 4);
    rst_i = 1'b1;
    @(posedge clk_i); #1;
    rst_i = 1'b0;
    @(posedge clk_i); #1;
    h.wr_byte(CMD_GET_CAL);
    h.rd_n(v, 4); chk("reread scale", GN, v);
    h.rd_n(v, 4); chk("reread gain", GN, v);
    h.rd_n(v, 4); chk("reread tare", TR, v);
    h.rd_n(v, 3); chk("reread ref", {8'h00, RF[23:0]}, v);
  endtask
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 20000) begin
      n_errors++;
      final_report;
    end
  end
  initial begin
    repeat (4) @(posedge clk_i); #1;
    rst_i = 1'b0;
    t_cal;
    t_modes;
    t_data;
    t_rst;
    final_report;
  end
endmodule
`default_nettype wire
